/* File: rtl/ssd_regs.vh */
// register map, bit positions and timing constants of the sensor diagnostic block
`ifndef SSD_REGS_VH
`define SSD_REGS_VH

// apb byte addresses
`define SSD_ADDR_DIAG      12'h000
`define SSD_ADDR_CTRL      12'h004
`define SSD_ADDR_IRQ_STAT  12'h008
`define SSD_ADDR_IRQ_MASK  12'h00c
`define SSD_ADDR_STATE     12'h010

// response byte bits
`define SSD_RSP_OUT_EN     0
`define SSD_RSP_ACT        1
`define SSD_RSP_INPUTS     4
`define SSD_RSP_LIMIT      5
`define SSD_RSP_WARN       6
`define SSD_RSP_FAIL       7

// request byte bit
`define SSD_REQ_FAIL_RST   7

// fault vector bits, shared by warning and failure bytes
`define SSD_FLT_OUT_A      0
`define SSD_FLT_OUT_B      1
`define SSD_FLT_CROSS      2
`define SSD_FLT_TEMP       3
`define SSD_FLT_ACT        4
`define SSD_FLT_INTERNAL   5
`define SSD_FLT_COMM       6

// control register fields
`define SSD_CTRL_RST_BIT   0
`define SSD_CTRL_SLOT_LSB  8
`define SSD_CTRL_SLOT_MSB  12

// interrupt status bits
`define SSD_IRQ_WARN       0
`define SSD_IRQ_FAIL       1
`define SSD_IRQ_REQ        2
`define SSD_IRQ_CLR        3
`define SSD_IRQ_W          4

// chain geometry and slot kinds
`define SSD_SLOT_W         5
`define SSD_MAX_CHAIN      5'd31
`define SSD_KIND_RSP       2'h0
`define SSD_KIND_WARN      2'h1
`define SSD_KIND_FAIL      2'h2
`define SSD_REFRESH_CYC    16'h0040

// escalation delay: minutes, seconds per minute, clock rate in hz
`define SSD_WARN_MIN       40'd30
`define SSD_SEC_PER_MIN    40'd60
`define SSD_CLK_HZ         40'd40000000

`endif

/* File: rtl/ssd_escalate.v */
// warning timer and latched failure state of one sensor
`timescale 1ns/1ps
`include "ssd_regs.vh"

module ssd_escalate #(
  parameter [39:0] WARN_CYCLES = `SSD_WARN_MIN * `SSD_SEC_PER_MIN * `SSD_CLK_HZ
) (
  input  wire       clk,
  input  wire       rstN,
  input  wire [6:0] fault,
  input  wire       resetReq,
  output reg        warnActive_q,
  output reg        failActive_q,
  output reg  [7:0] warnByte_q,
  output reg  [7:0] failByte_q,
  output reg        warnStart_q,
  output reg        failStart_q,
  output reg        failClear_q
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WARN = 2'd1;
  localparam ST_FAIL = 2'd2;

  reg  [1:0]  state_q;
  reg  [39:0] cnt_q;
  wire        warnCond = |fault[`SSD_FLT_TEMP:`SSD_FLT_OUT_A];
  wire        hardCond = fault[`SSD_FLT_ACT] | fault[`SSD_FLT_INTERNAL];
  wire        anyFault = warnCond | hardCond;

  // actuator and internal faults skip the warning, output, cross and temp faults get the grace delay, comm faults do neither
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q      <= ST_IDLE;
      cnt_q        <= 40'h0;
      warnActive_q <= 1'b0;
      failActive_q <= 1'b0;
      warnByte_q   <= 8'h00;
      failByte_q   <= 8'h00;
      warnStart_q  <= 1'b0;
      failStart_q  <= 1'b0;
      failClear_q  <= 1'b0;
    end else begin
      warnStart_q <= 1'b0;
      failStart_q <= 1'b0;
      failClear_q <= 1'b0;
      warnByte_q  <= {1'b0, fault[`SSD_FLT_COMM], fault[`SSD_FLT_INTERNAL], 1'b0,
                      fault[`SSD_FLT_TEMP:`SSD_FLT_OUT_A]};
      case (state_q)
        ST_IDLE: begin
          if (hardCond) begin
            state_q      <= ST_FAIL;
            failActive_q <= 1'b1;
            failStart_q  <= 1'b1;
            failByte_q   <= {2'b00, fault[`SSD_FLT_INTERNAL:`SSD_FLT_OUT_A]};
          end else if (warnCond) begin
            state_q      <= ST_WARN;
            warnActive_q <= 1'b1;
            warnStart_q  <= 1'b1;
            cnt_q        <= 40'h0;
          end
        end
        ST_WARN: begin
          if (hardCond || cnt_q == WARN_CYCLES - 40'd1) begin
            state_q      <= ST_FAIL;
            warnActive_q <= 1'b0;
            failActive_q <= 1'b1;
            failStart_q  <= 1'b1;
            failByte_q   <= {2'b00, fault[`SSD_FLT_INTERNAL:`SSD_FLT_OUT_A]};
          end else if (!warnCond) begin
            state_q      <= ST_IDLE;
            warnActive_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 40'd1;
          end
        end
        ST_FAIL: begin
          // reset is refused while any fault other than comm is still seen
          if (resetReq && !anyFault) begin
            state_q      <= ST_IDLE;
            failActive_q <= 1'b0;
            failByte_q   <= 8'h00;
            failClear_q  <= 1'b1;
          end else begin
            failByte_q <= failByte_q | {2'b00, fault[`SSD_FLT_INTERNAL:`SSD_FLT_OUT_A]};
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ssd_escalate

/* File: rtl/ssd_chain_link.v */
// pass-through of the serial diagnostic chain with own slot insertion
`timescale 1ns/1ps
`include "ssd_regs.vh"

module ssd_chain_link #(
  parameter [15:0] REFRESH_CYC = `SSD_REFRESH_CYC
) (
  input  wire       clk,
  input  wire       rstN,
  input  wire [4:0] ownSlot,
  input  wire [7:0] ownResp,
  input  wire [7:0] ownWarn,
  input  wire [7:0] ownFail,
  input  wire       reqInValid,
  input  wire [4:0] reqInSlot,
  input  wire [7:0] reqInByte,
  output reg        reqOutValid_q,
  output reg  [4:0] reqOutSlot_q,
  output reg  [7:0] reqOutByte_q,
  input  wire       rspInValid,
  input  wire [4:0] rspInSlot,
  input  wire [1:0] rspInKind,
  input  wire [7:0] rspInByte,
  output reg        rspOutValid_q,
  output reg  [4:0] rspOutSlot_q,
  output reg  [1:0] rspOutKind_q,
  output reg  [7:0] rspOutByte_q,
  output reg        reqHit_q,
  output reg  [7:0] reqByte_q
);

  reg  [15:0] refresh_q;
  reg         pend_q;
  reg  [1:0]  kind_q;
  wire        reqMine = reqInValid && reqInSlot == ownSlot;
  wire        emitOwn = pend_q && !rspInValid;
  reg  [7:0]  ownByte;

  always @* begin
    case (kind_q)
      `SSD_KIND_WARN: ownByte = ownWarn;
      `SSD_KIND_FAIL: ownByte = ownFail;
      default:        ownByte = ownResp;
    endcase
  end

  // downstream traffic first so the chain never stalls; own bytes wait
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      refresh_q     <= 16'h0000;
      pend_q        <= 1'b0;
      kind_q        <= `SSD_KIND_RSP;
      reqOutValid_q <= 1'b0;
      reqOutSlot_q  <= 5'h00;
      reqOutByte_q  <= 8'h00;
      rspOutValid_q <= 1'b0;
      rspOutSlot_q  <= 5'h00;
      rspOutKind_q  <= `SSD_KIND_RSP;
      rspOutByte_q  <= 8'h00;
      reqHit_q      <= 1'b0;
      reqByte_q     <= 8'h00;
    end else begin
      refresh_q <= (refresh_q == REFRESH_CYC - 16'd1) ? 16'h0000 : refresh_q + 16'd1;
      if (refresh_q == REFRESH_CYC - 16'd1) begin
        pend_q <= 1'b1;
      end else if (emitOwn) begin
        pend_q <= 1'b0;
      end
      if (emitOwn) begin
        kind_q <= (kind_q == `SSD_KIND_FAIL) ? `SSD_KIND_RSP : kind_q + 2'd1;
      end
      rspOutValid_q <= rspInValid | emitOwn;
      rspOutSlot_q  <= rspInValid ? rspInSlot : ownSlot;
      rspOutKind_q  <= rspInValid ? rspInKind : kind_q;
      rspOutByte_q  <= rspInValid ? rspInByte : ownByte;
      reqOutValid_q <= reqInValid & ~reqMine;
      reqOutSlot_q  <= reqInSlot;
      reqOutByte_q  <= reqInByte;
      reqHit_q      <= reqMine;
      if (reqMine) begin
        reqByte_q <= reqInByte;
      end
    end
  end

endmodule // ssd_chain_link

/* File: rtl/ssd_sensor_diag.v */
// serial diagnostic status logic of one chained safety sensor, with apb registers
`timescale 1ns/1ps
`include "ssd_regs.vh"

module ssd_sensor_diag #(
  parameter [39:0] WARN_CYCLES = `SSD_WARN_MIN * `SSD_SEC_PER_MIN * `SSD_CLK_HZ,
  parameter [15:0] REFRESH_CYC = `SSD_REFRESH_CYC
) (
  input  wire        clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata_q,
  output wire        pslverr,
  output wire        irq,
  // sensing front end
  input  wire        actuatorPresent,
  input  wire        actuatorValid,
  input  wire        actuatorLimit,
  input  wire        safety_input_a,
  input  wire        safety_input_b,
  input  wire        faultOutA,
  input  wire        faultOutB,
  input  wire        faultCross,
  input  wire        faultTemp,
  input  wire        faultActuator,
  input  wire        faultInternal,
  input  wire        faultComm,
  output reg         safety_output_a,
  output reg         safety_output_b,
  // request path, upstream in and downstream out
  input  wire        reqInValid,
  input  wire [4:0]  reqInSlot,
  input  wire [7:0]  reqInByte,
  output wire        reqOutValid,
  output wire [4:0]  reqOutSlot,
  output wire [7:0]  reqOutByte,
  // response path, downstream in and upstream out
  input  wire        rspInValid,
  input  wire [4:0]  rspInSlot,
  input  wire [1:0]  rspInKind,
  input  wire [7:0]  rspInByte,
  output wire        rspOutValid,
  output wire [4:0]  rspOutSlot,
  output wire [1:0]  rspOutKind,
  output wire [7:0]  rspOutByte
);

  // reset release through two flops; assertion stays asynchronous
  reg         rstMeta_q;
  reg         rstSync_q;
  wire        rstN = rstSync_q;

  // software visible state
  reg  [4:0]  slot_q;
  reg  [`SSD_IRQ_W-1:0] irqStat_q;
  reg  [`SSD_IRQ_W-1:0] irqMask_q;
  reg  [7:0]  failCount_q;
  reg         swReset_q;
  reg  [7:0]  resp_q;

  // bus decode
  wire        setupPh  = psel & ~penable;
  wire        accessPh = psel & penable;
  reg         addrHit;
  wire        wrEn     = accessPh & pwrite & addrHit;

  // escalation outputs
  wire        warnActive;
  wire        failActive;
  wire [7:0]  warnByte;
  wire [7:0]  failByte;
  wire        warnStart;
  wire        failStart;
  wire        failClear;

  // chain request capture
  wire        reqHit;
  wire [7:0]  reqByte;

  // condition terms
  wire        actuated;
  wire        inputsOk;
  wire        outEn;
  wire        failResetReq;
  wire [6:0]  faultVec;
  reg  [7:0]  respNext;
  reg  [`SSD_IRQ_W-1:0] irqEvent;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // sensing conditions, all active high
  assign actuated = actuatorPresent & actuatorValid;
  assign inputsOk = safety_input_a & safety_input_b;
  // warning does not drop the outputs, only a latched failure does
  assign outEn    = actuated & inputsOk & ~failActive;

  assign faultVec = {faultComm, faultInternal, faultActuator, faultTemp,
                     faultCross, faultOutB, faultOutA};

  // failure reset from the chain request byte or from software
  assign failResetReq = (reqHit & reqByte[`SSD_REQ_FAIL_RST]) | swReset_q;

  // response byte; input and limit bits gated by actuation so idle reads zero
  always @* begin
    respNext                  = 8'h00;
    respNext[`SSD_RSP_OUT_EN] = outEn;
    respNext[`SSD_RSP_ACT]    = actuated;
    respNext[`SSD_RSP_INPUTS] = inputsOk & actuated;
    respNext[`SSD_RSP_LIMIT]  = actuatorLimit & actuated;
    respNext[`SSD_RSP_WARN]   = warnActive;
    respNext[`SSD_RSP_FAIL]   = failActive;
  end

  // response byte and the outputs share one edge so they never disagree
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      resp_q          <= 8'h00;
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
    end else begin
      resp_q          <= respNext;
      safety_output_a <= outEn;
      safety_output_b <= outEn;
    end
  end

  ssd_escalate #(
    .WARN_CYCLES (WARN_CYCLES)
  ) uEscalate (
    .clk          (clk),
    .rstN         (rstN),
    .fault        (faultVec),
    .resetReq     (failResetReq),
    .warnActive_q (warnActive),
    .failActive_q (failActive),
    .warnByte_q   (warnByte),
    .failByte_q   (failByte),
    .warnStart_q  (warnStart),
    .failStart_q  (failStart),
    .failClear_q  (failClear)
  );

  ssd_chain_link #(
    .REFRESH_CYC (REFRESH_CYC)
  ) uChain (
    .clk           (clk),
    .rstN          (rstN),
    .ownSlot       (slot_q),
    .ownResp       (resp_q),
    .ownWarn       (warnByte),
    .ownFail       (failByte),
    .reqInValid    (reqInValid),
    .reqInSlot     (reqInSlot),
    .reqInByte     (reqInByte),
    .reqOutValid_q (reqOutValid),
    .reqOutSlot_q  (reqOutSlot),
    .reqOutByte_q  (reqOutByte),
    .rspInValid    (rspInValid),
    .rspInSlot     (rspInSlot),
    .rspInKind     (rspInKind),
    .rspInByte     (rspInByte),
    .rspOutValid_q (rspOutValid),
    .rspOutSlot_q  (rspOutSlot),
    .rspOutKind_q  (rspOutKind),
    .rspOutByte_q  (rspOutByte),
    .reqHit_q      (reqHit),
    .reqByte_q     (reqByte)
  );

  // address decode
  always @* begin
    case (paddr)
      `SSD_ADDR_DIAG:     addrHit = 1'b1;
      `SSD_ADDR_CTRL:     addrHit = 1'b1;
      `SSD_ADDR_IRQ_STAT: addrHit = 1'b1;
      `SSD_ADDR_IRQ_MASK: addrHit = 1'b1;
      `SSD_ADDR_STATE:    addrHit = 1'b1;
      default:            addrHit = 1'b0;
    endcase
  end

  // zero wait state: access phase always completes in one cycle
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~addrHit;

  // read data latched in setup so it is stable across the access phase
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prdata_q <= 32'h00000000;
    end else if (setupPh) begin
      case (paddr)
        `SSD_ADDR_DIAG:     prdata_q <= {8'h00, failByte, warnByte, resp_q};
        `SSD_ADDR_CTRL:     prdata_q <= {19'h00000, slot_q, 8'h00};
        `SSD_ADDR_IRQ_STAT: prdata_q <= {28'h0000000, irqStat_q};
        `SSD_ADDR_IRQ_MASK: prdata_q <= {28'h0000000, irqMask_q};
        `SSD_ADDR_STATE:    prdata_q <= {16'h0000, failCount_q, reqByte};
        default:            prdata_q <= 32'h00000000;
      endcase
    end
  end

  // control: chain slot and a one-cycle software failure reset
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      slot_q    <= 5'h00;
      swReset_q <= 1'b0;
      irqMask_q <= {`SSD_IRQ_W{1'b0}};
    end else begin
      swReset_q <= wrEn && paddr == `SSD_ADDR_CTRL && pwdata[`SSD_CTRL_RST_BIT];
      // slots beyond the chain length are refused, old slot kept
      if (wrEn && paddr == `SSD_ADDR_CTRL &&
          pwdata[`SSD_CTRL_SLOT_MSB:`SSD_CTRL_SLOT_LSB] < `SSD_MAX_CHAIN) begin
        slot_q <= pwdata[`SSD_CTRL_SLOT_MSB:`SSD_CTRL_SLOT_LSB];
      end
      if (wrEn && paddr == `SSD_ADDR_IRQ_MASK) begin
        irqMask_q <= pwdata[`SSD_IRQ_W-1:0];
      end
    end
  end

  // interrupt events
  always @* begin
    irqEvent                = {`SSD_IRQ_W{1'b0}};
    irqEvent[`SSD_IRQ_WARN] = warnStart;
    irqEvent[`SSD_IRQ_FAIL] = failStart;
    irqEvent[`SSD_IRQ_REQ]  = reqHit;
    irqEvent[`SSD_IRQ_CLR]  = failClear;
  end

  // sticky status, write one to clear; a new event in the same cycle wins
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqStat_q   <= {`SSD_IRQ_W{1'b0}};
      failCount_q <= 8'h00;
    end else begin
      if (wrEn && paddr == `SSD_ADDR_IRQ_STAT) begin
        irqStat_q <= (irqStat_q & ~pwdata[`SSD_IRQ_W-1:0]) | irqEvent;
      end else begin
        irqStat_q <= irqStat_q | irqEvent;
      end
      // saturating so a flapping fault cannot wrap the count to zero
      if (failStart && failCount_q != 8'hff) begin
        failCount_q <= failCount_q + 8'h01;
      end
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

endmodule // ssd_sensor_diag

/* File: sim/ssd_diag_assertions.sv */
// port assertions of the sensor diagnostic block
`timescale 1ns/1ps
`include "ssd_regs.vh"
module ssd_diag_assertions #(
  parameter [39:0] WARN_CYCLES = 40'd20,
  parameter [15:0] REFRESH_CYC = 16'h0008
) (
  input wire        clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata_q,
  input wire        pslverr,
  input wire        actuatorPresent,
  input wire        faultOutA,
  input wire        faultTemp,
  input wire        safety_output_a,
  input wire        safety_output_b,
  input wire        rspInValid,
  input wire [4:0]  rspInSlot,
  input wire [1:0]  rspInKind,
  input wire [7:0]  rspInByte,
  input wire        rspOutValid,
  input wire [4:0]  rspOutSlot,
  input wire [1:0]  rspOutKind,
  input wire [7:0]  rspOutByte
);
  localparam int RMAX = 2 * REFRESH_CYC + 4;
  logic [39:0] warnCnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // cycles a warned fault is held; margin covers the reset synchroniser
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) warnCnt_q <= 40'h0;
    else if (!(faultOutA || faultTemp)) warnCnt_q <= 40'h0;
    else if (warnCnt_q <= WARN_CYCLES + 40'd6) warnCnt_q <= warnCnt_q + 40'd1;
  end

  // access phase of a diagnostic word read
  sequence s_diag_rd;
    psel && penable && !pwrite && paddr == `SSD_ADDR_DIAG;
  endsequence
  sequence s_warn_spent;
    warnCnt_q > WARN_CYCLES + 40'd5;
  endsequence

  a_resp_pass: assert property (rspInValid |=> rspOutValid &&
    rspOutSlot == $past(rspInSlot) && rspOutKind == $past(rspInKind) &&
    rspOutByte == $past(rspInByte)) else $error("downstream byte not passed on");
  a_own_refresh: assert property ($fell(rspOutValid) && !rspInValid |->
    ##[1:RMAX] rspOutValid) else $error("own bytes not refreshed");
  a_spare_zero: assert property (s_diag_rd |-> prdata_q[3:2] == 2'b00)
    else $error("response bits 2 and 3 set");
  a_fail_off: assert property (s_diag_rd ##0 prdata_q[7] |-> !prdata_q[0])
    else $error("failure with outputs enabled");
  a_limit_keep: assert property (s_diag_rd ##0 prdata_q[5] && !prdata_q[7] |->
    prdata_q[4] && prdata_q[1] && prdata_q[0]) else $error("limit area dropped bits");
  a_warn_keep: assert property (s_diag_rd ##0 prdata_q[6] && !prdata_q[7] &&
    prdata_q[4] && prdata_q[1] |-> prdata_q[0]) else $error("warning cut outputs");
  a_idle_off: assert property (!actuatorPresent |=> !safety_output_a && !safety_output_b)
    else $error("outputs on without actuator");
  a_escalate_bound: assert property (s_warn_spent |->
    !safety_output_a && !safety_output_b) else $error("warning not escalated in time");
  a_unmapped_err: assert property (psel && penable && paddr > `SSD_ADDR_STATE |->
    pslverr && prdata_q == 32'h0) else $error("unmapped access accepted");
endmodule // ssd_diag_assertions

bind ssd_sensor_diag ssd_diag_assertions #(.WARN_CYCLES(WARN_CYCLES),
  .REFRESH_CYC(REFRESH_CYC)) uChk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_q(prdata_q),
  .pslverr(pslverr), .actuatorPresent(actuatorPresent), .faultOutA(faultOutA),
  .faultTemp(faultTemp), .safety_output_a(safety_output_a),
  .safety_output_b(safety_output_b), .rspInValid(rspInValid), .rspInSlot(rspInSlot),
  .rspInKind(rspInKind), .rspInByte(rspInByte), .rspOutValid(rspOutValid),
  .rspOutSlot(rspOutSlot), .rspOutKind(rspOutKind), .rspOutByte(rspOutByte));

/* File: sim/ssd_gateway_model.sv */
// gateway side of the chain: issues bytes, logs upstream traffic
`timescale 1ns/1ps
module ssd_gateway_model (
  input  wire        clk,
  output logic       reqInValid,
  output logic [4:0] reqInSlot,
  output logic [7:0] reqInByte,
  input  wire        reqOutValid,
  input  wire  [4:0] reqOutSlot,
  input  wire  [7:0] reqOutByte,
  output logic       rspInValid,
  output logic [4:0] rspInSlot,
  output logic [1:0] rspInKind,
  output logic [7:0] rspInByte,
  input  wire        rspOutValid,
  input  wire  [4:0] rspOutSlot,
  input  wire  [1:0] rspOutKind,
  input  wire  [7:0] rspOutByte
);
  logic [7:0]  upByte [0:127];
  logic [12:0] lastFwd;

  // idle lines show a pattern, never a stale byte
  initial begin
    {reqInValid, rspInValid} = 2'b00;
    {reqInSlot, reqInByte} = 13'h1555;
    {rspInSlot, rspInKind, rspInByte} = 15'h2aaa;
  end

  // upstream bytes by slot and kind; last forwarded request
  always @(posedge clk) begin
    if (rspOutValid) upByte[{rspOutSlot, rspOutKind}] <= rspOutByte;
    if (reqOutValid) lastFwd <= {reqOutSlot, reqOutByte};
  end

  // one request byte, one edge long; lines inverted after
  task automatic send_req(input logic [4:0] s, input logic [7:0] b);
    reqInValid <= 1'b1;
    {reqInSlot, reqInByte} <= {s, b};
    @(posedge clk);
    reqInValid <= 1'b0;
    {reqInSlot, reqInByte} <= ~{s, b};
    @(posedge clk);
  endtask

  // one downstream response byte
  task automatic send_rsp(input logic [4:0] s, input logic [1:0] k, input logic [7:0] b);
    rspInValid <= 1'b1;
    {rspInSlot, rspInKind, rspInByte} <= {s, k, b};
    @(posedge clk);
    rspInValid <= 1'b0;
    {rspInSlot, rspInKind, rspInByte} <= ~{s, k, b};
    @(posedge clk);
  endtask
endmodule // ssd_gateway_model

/* File: sim/ssd_sensor_diag_tb.sv */
// self-checking bench of the sensor diagnostic block
`timescale 1ns/1ps
`include "ssd_regs.vh"
module ssd_sensor_diag_tb;
  logic        clk, rst_n, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [4:0]  sen;
  logic [6:0]  flt;
  wire         pready, pslverr, irq, oA, oB, qIv, qOv, sIv, sOv;
  wire  [31:0] prdata;
  wire  [4:0]  qIs, qOs, sIs, sOs;
  wire  [7:0]  qIb, qOb, sIb, sOb;
  wire  [1:0]  sIk, sOk;
  int          fails = 0;
  int          nTests = 0;
  int          wc[5] = '{0, 1, 2, 3, 6};

  // sen: present, valid, limit, input a, input b
  ssd_sensor_diag #(.WARN_CYCLES(40'd20), .REFRESH_CYC(16'h0008)) DUT (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata_q(prdata), .pslverr(pslverr),
    .irq(irq), .actuatorPresent(sen[0]), .actuatorValid(sen[1]), .actuatorLimit(sen[2]),
    .safety_input_a(sen[3]), .safety_input_b(sen[4]), .faultOutA(flt[0]),
    .faultOutB(flt[1]), .faultCross(flt[2]), .faultTemp(flt[3]), .faultActuator(flt[4]),
    .faultInternal(flt[5]), .faultComm(flt[6]), .safety_output_a(oA), .safety_output_b(oB),
    .reqInValid(qIv), .reqInSlot(qIs), .reqInByte(qIb), .reqOutValid(qOv),
    .reqOutSlot(qOs), .reqOutByte(qOb), .rspInValid(sIv), .rspInSlot(sIs),
    .rspInKind(sIk), .rspInByte(sIb), .rspOutValid(sOv), .rspOutSlot(sOs),
    .rspOutKind(sOk), .rspOutByte(sOb));
  ssd_gateway_model gw (.clk(clk), .reqInValid(qIv), .reqInSlot(qIs), .reqInByte(qIb),
    .reqOutValid(qOv), .reqOutSlot(qOs), .reqOutByte(qOb), .rspInValid(sIv),
    .rspInSlot(sIs), .rspInKind(sIk), .rspInByte(sIb), .rspOutValid(sOv),
    .rspOutSlot(sOs), .rspOutKind(sOk), .rspOutByte(sOb));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic stopTest;
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk);
    if (n >= 20) begin
      fails++;
      stopTest();
    end
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, sen, flt} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // idle sensor, then an unmapped place
    rdChk(`SSD_ADDR_DIAG, 32'h0);
    check({oA, oB}, 32'h0);
    check(err, 32'h0);
    rdChk(12'h020, 32'h0);
    check(err, 32'h1);
    // own slot 5, actuated with outputs released
    apb(1'b1, `SSD_ADDR_CTRL, 32'h0000_0500);
    sen <= 5'h1b;
    repeat (3) @(posedge clk);
    rdChk(`SSD_ADDR_DIAG, 32'h13);
    check({oA, oB}, 32'h3);
    repeat (40) @(posedge clk);
    check(gw.upByte[{5'd5, 2'd0}], 32'h13);
    sen <= 5'h1f;
    repeat (3) @(posedge clk);
    rdChk(`SSD_ADDR_DIAG, 32'h33);
    // one safety input dropped, then an actuator that is not identified
    sen <= 5'h0b;
    repeat (3) @(posedge clk);
    rdChk(`SSD_ADDR_DIAG, 32'h02);
    check({oA, oB}, 32'h0);
    sen <= 5'h19;
    repeat (3) @(posedge clk);
    rdChk(`SSD_ADDR_DIAG, 32'h0);
    check({oA, oB}, 32'h0);
    sen <= 5'h1b;
    // each grace-delayed code alone, then comm, lifted well before escalation
    foreach (wc[k]) begin
      flt <= 7'h1 << wc[k];
      repeat (3) @(posedge clk);
      apb(1'b0, `SSD_ADDR_DIAG, 32'h0);
      check(rd[15:0], {8'h1 << wc[k], (wc[k] == 6) ? 8'h13 : 8'h53});
      check({oA, oB}, 32'h3);
      flt <= 7'h0;
      repeat (3) @(posedge clk);
    end
    // interrupt masked, unmasked, cleared
    rdChk(`SSD_ADDR_IRQ_STAT, 32'h1);
    check(irq, 32'h0);
    apb(1'b1, `SSD_ADDR_IRQ_MASK, 32'hf);
    check(irq, 32'h1);
    apb(1'b1, `SSD_ADDR_IRQ_STAT, 32'hf);
    check(irq, 32'h0);
    // warning left standing escalates
    flt <= 7'h08;
    repeat (30) @(posedge clk);
    rdChk(`SSD_ADDR_DIAG, 32'h0008_0892);
    check({oA, oB}, 32'h0);
    rdChk(`SSD_ADDR_IRQ_STAT, 32'h3);
    apb(1'b1, `SSD_ADDR_IRQ_STAT, 32'hf);
    // reset request refused while the fault stands
    gw.send_req(5'd5, 8'h80);
    repeat (4) @(posedge clk);
    rdChk(`SSD_ADDR_DIAG, 32'h0008_0892);
    rdChk(`SSD_ADDR_STATE, 32'h0000_0180);
    flt <= 7'h0;
    repeat (3) @(posedge clk);
    gw.send_req(5'd5, 8'h80);
    repeat (4) @(posedge clk);
    rdChk(`SSD_ADDR_DIAG, 32'h13);
    check({oA, oB}, 32'h3);
    rdChk(`SSD_ADDR_IRQ_STAT, 32'hc);
    // foreign request and downstream byte pass through
    gw.send_req(5'd3, 8'h5a);
    repeat (2) @(posedge clk);
    check(gw.lastFwd, {19'h0, 5'd3, 8'h5a});
    gw.send_rsp(5'd7, 2'd1, 8'h44);
    repeat (2) @(posedge clk);
    check(gw.upByte[{5'd7, 2'd1}], 32'h44);
    // faults that fail at once, failure byte accumulates
    flt <= 7'h20;
    repeat (4) @(posedge clk);
    apb(1'b0, `SSD_ADDR_DIAG, 32'h0);
    check({rd[23:16], rd[7:0]}, 32'h2092);
    flt <= 7'h30;
    repeat (4) @(posedge clk);
    apb(1'b0, `SSD_ADDR_DIAG, 32'h0);
    check({rd[23:16], rd[7:0]}, 32'h3092);
    // software reset once faults are gone; slot 31 is refused, reset still applies
    flt <= 7'h0;
    repeat (2) @(posedge clk);
    apb(1'b1, `SSD_ADDR_CTRL, 32'h0000_1f01);
    repeat (2) @(posedge clk);
    rdChk(`SSD_ADDR_DIAG, 32'h13);
    check({oA, oB}, 32'h3);
    rdChk(`SSD_ADDR_CTRL, 32'h0000_0500);
    rdChk(`SSD_ADDR_STATE, 32'h0000_0280);
    stopTest();
  end
endmodule // ssd_sensor_diag_tb
